// File: hdl/rx_object_store.sv
// Receive object store: writes received frames as objects into message RAM
// and serves the host's register and RAM reads.
// Assumes the frame assembler and host port run on the same clock.
// Function
// - Identifier word holds standard id in 10:0, extended id in 28:11.
// - Bit 29 of identifier word carries the twelfth identifier bit.
// - Control word bits 15:11 hold the matched filter index.
// - Control word bit 8 holds the error state indicator.
// - Control word bit 7 set for FD frames, clear for classic.
// - Control word bit 6 set when data phase used the fast rate.
// - Control word bit 5 holds the remote request flag.
// - Control word bit 4 holds the identifier extension flag.
// - Control word bits 3:0 hold the data length code.
// - Classic remote request stored in a FIFO asks the device to transmit a frame; one dropped on a full FIFO does not.
// - Per-FIFO enable inserts a timestamp as the third object word.
// - Payload packs four bytes per word, lowest byte in bits 7:0.
// - Per-FIFO 3-bit field sets reserved payload space per object.
// - Device keeps per-FIFO user address; host adds 0x400 for RAM.
// - Host sets user increment; device advances tail and user address unless the FIFO is empty.
// - Unimplemented object bits read as zero; software ignores them.
`timescale 1ns/1ps
`default_nettype none
module rx_object_store (
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire can_rx_obj_pkg::rx_header_t    hdr,
    input  wire logic                          hdr_valid,
    output logic                               hdr_ready,
    input  wire can_rx_obj_pkg::payload_beat_t beat,
    input  wire logic                          beat_valid,
    output logic                               beat_ready,
    input  wire logic [11:0]                   host_addr,
    input  wire logic                          host_rd,
    input  wire logic                          host_wr,
    input  wire logic [31:0]                   host_wdata,
    output logic      [31:0]                   host_rdata,
    output logic                               host_rvalid,
    output logic                               remote_request,
    output logic                               overflow_drop
);
    // ==========================================================
    // Helper functions
    // ==========================================================
    function automatic logic [4:0] pl_words(input logic [2:0] sel);
        unique case (sel)
            3'h0: pl_words = 5'h02;
            3'h1: pl_words = 5'h03;
            3'h2: pl_words = 5'h04;
            3'h3: pl_words = 5'h05;
            3'h4: pl_words = 5'h06;
            3'h5: pl_words = 5'h08;
            3'h6: pl_words = 5'h0c;
            3'h7: pl_words = 5'h10;
        endcase
    endfunction

    function automatic logic [11:0] obj_offset(input logic f,
            input logic [1:0] slot, input logic ts, input logic [2:0] sel);
        logic [4:0] words;
        words = 5'h02 + 5'(ts) + pl_words(sel);
        obj_offset = (f ? can_rx_obj_pkg::REGION_BYTES : 12'h000)
                   + 12'({slot, 2'b00}) * 12'(words);
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    logic [31:0] ram [can_rx_obj_pkg::RAM_WORDS];
    can_rx_obj_pkg::wr_state_t state_reg;
    can_rx_obj_pkg::wr_state_t state_next;
    can_rx_obj_pkg::rx_header_t hdr_reg;
    logic [7:0]  wr_ptr_reg;
    logic [4:0]  word_cnt_reg;
    logic [31:0] stamp_reg;
    logic        hdr_ready_reg;
    logic [31:0] rdata_reg;
    logic        rvalid_reg;
    logic        remote_reg;
    logic        drop_reg;
    logic        ts_en_reg [can_rx_obj_pkg::NUM_FIFO];
    logic [2:0]  plsel_reg [can_rx_obj_pkg::NUM_FIFO];
    logic [can_rx_obj_pkg::PTR_W-1:0] head_reg [can_rx_obj_pkg::NUM_FIFO];
    logic [can_rx_obj_pkg::PTR_W-1:0] tail_reg [can_rx_obj_pkg::NUM_FIFO];

    can_rx_obj_pkg::payload_beat_t buf_beat;
    logic        buf_valid;
    wire         buf_ready = state_reg == can_rx_obj_pkg::ST_DATA
                          || state_reg == can_rx_obj_pkg::ST_DRAIN;
    wire         buf_pop   = buf_valid && buf_ready;

    beat_buffer #(
        .WIDTH (can_rx_obj_pkg::BEAT_W),
        .DEPTH (can_rx_obj_pkg::BUF_DEPTH)
    ) u_beat_buffer (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (beat_valid),
        .in_ready  (beat_ready),
        .in_data   (beat),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_beat)
    );

    // ==========================================================
    // Object writer decode
    // ==========================================================
    wire        f        = hdr_reg.target_fifo;
    wire        f_ts     = ts_en_reg[f];
    wire [4:0]  f_plw    = pl_words(plsel_reg[f]);
    wire [can_rx_obj_pkg::PTR_W-1:0] f_fill = head_reg[f] - tail_reg[f];
    wire        f_full   = f_fill == can_rx_obj_pkg::PTR_W'(
                               can_rx_obj_pkg::OBJ_DEPTH);
    wire        hdr_take = hdr_valid && hdr_ready_reg;
    wire        has_data = hdr_reg.dlc != 4'h0;
    wire [11:0] new_ofs  = obj_offset(hdr.target_fifo,
                               head_reg[hdr.target_fifo][1:0],
                               ts_en_reg[hdr.target_fifo],
                               plsel_reg[hdr.target_fifo]);
    wire        data_fit = word_cnt_reg < f_plw;
    logic [31:0] id_word;
    logic [31:0] ctrl_word;
    logic [31:0] ram_wdata;
    logic        ram_we;

    always_comb begin
        id_word   = 32'h0000_0000;
        ctrl_word = 32'h0000_0000;
        id_word[can_rx_obj_pkg::SID_LSB +: 11] = hdr_reg.sid;
        id_word[can_rx_obj_pkg::EID_LSB +: 18] = hdr_reg.eid;
        id_word[can_rx_obj_pkg::ID12_BIT] =
            hdr_reg.twelfth_identifier_bit;
        ctrl_word[can_rx_obj_pkg::FILT_LSB +: 5] =
            hdr_reg.matched_filter_index;
        ctrl_word[can_rx_obj_pkg::ESI_BIT] = hdr_reg.esi;
        ctrl_word[can_rx_obj_pkg::FDF_BIT] = hdr_reg.fdf;
        ctrl_word[can_rx_obj_pkg::BRS_BIT] =
            hdr_reg.fast_data_rate;
        ctrl_word[can_rx_obj_pkg::RTR_BIT] = hdr_reg.rtr;
        ctrl_word[can_rx_obj_pkg::IDE_BIT] = hdr_reg.ide;
        ctrl_word[can_rx_obj_pkg::DLC_LSB +: 4] = hdr_reg.dlc;
    end

    always_comb begin
        state_next = state_reg;
        ram_we     = 1'b0;
        ram_wdata  = 32'h0000_0000;
        unique case (state_reg)
            can_rx_obj_pkg::ST_IDLE:
                if (hdr_take) state_next = can_rx_obj_pkg::ST_ID;
            can_rx_obj_pkg::ST_ID:
                if (f_full) begin
                    state_next = has_data ? can_rx_obj_pkg::ST_DRAIN
                                          : can_rx_obj_pkg::ST_IDLE;
                end else begin
                    ram_we     = 1'b1;
                    ram_wdata  = id_word;
                    state_next = can_rx_obj_pkg::ST_CTRL;
                end
            can_rx_obj_pkg::ST_CTRL: begin
                ram_we    = 1'b1;
                ram_wdata = ctrl_word;
                if (f_ts) state_next = can_rx_obj_pkg::ST_STAMP;
                else if (has_data) state_next = can_rx_obj_pkg::ST_DATA;
                else state_next = can_rx_obj_pkg::ST_DONE;
            end
            can_rx_obj_pkg::ST_STAMP: begin
                ram_we     = 1'b1;
                ram_wdata  = stamp_reg;
                state_next = has_data ? can_rx_obj_pkg::ST_DATA
                                      : can_rx_obj_pkg::ST_DONE;
            end
            can_rx_obj_pkg::ST_DATA:
                if (buf_valid) begin
                    ram_we    = data_fit;
                    ram_wdata = {buf_beat.bytes[3], buf_beat.bytes[2],
                                 buf_beat.bytes[1], buf_beat.bytes[0]};
                    if (buf_beat.last) state_next = can_rx_obj_pkg::ST_DONE;
                end
            can_rx_obj_pkg::ST_DRAIN:
                if (buf_valid && buf_beat.last)
                    state_next = can_rx_obj_pkg::ST_IDLE;
            can_rx_obj_pkg::ST_DONE:
                state_next = can_rx_obj_pkg::ST_IDLE;
            default:
                state_next = can_rx_obj_pkg::ST_IDLE;
        endcase
    end

    // ==========================================================
    // Host register decode
    // ==========================================================
    wire        ram_sel  = host_addr >= can_rx_obj_pkg::RAM_BASE
                        && host_addr <  can_rx_obj_pkg::RAM_END;
    wire        sfr_sel  = host_addr < can_rx_obj_pkg::SFR_END;
    wire        sfr_f    = host_addr[can_rx_obj_pkg::SFR_FIFO_BIT];
    wire [3:0]  sfr_reg  = host_addr[3:0];
    wire [11:0] ram_ofs  = host_addr - can_rx_obj_pkg::RAM_BASE;
    wire [can_rx_obj_pkg::PTR_W-1:0] sel_fill =
        head_reg[sfr_f] - tail_reg[sfr_f];
    wire [can_rx_obj_pkg::PTR_W-1:0] sel_tail = tail_reg[sfr_f];
    wire        sel_nempty = sel_fill != '0;
    wire        ctrl_wr  = host_wr && sfr_sel
                        && sfr_reg == can_rx_obj_pkg::CTRL_OFS;
    wire        user_increment_req = ctrl_wr
                        && host_wdata[can_rx_obj_pkg::INC_BIT];
    wire        user_increment_hit = user_increment_req && sel_nempty;
    wire [11:0] sel_ua   = obj_offset(sfr_f, sel_tail[1:0],
                               ts_en_reg[sfr_f], plsel_reg[sfr_f]);
    logic [31:0] sfr_rdata;

    always_comb begin
        sfr_rdata = 32'h0000_0000;
        if (sfr_reg == can_rx_obj_pkg::CTRL_OFS) begin
            sfr_rdata[can_rx_obj_pkg::TSEN_BIT] = ts_en_reg[sfr_f];
            sfr_rdata[can_rx_obj_pkg::PLSEL_LSB +: 3] = plsel_reg[sfr_f];
        end else if (sfr_reg == can_rx_obj_pkg::STAT_OFS) begin
            sfr_rdata[can_rx_obj_pkg::NEMPTY_BIT] = sel_nempty;
            sfr_rdata[can_rx_obj_pkg::FULL_BIT] = sel_fill ==
                can_rx_obj_pkg::PTR_W'(can_rx_obj_pkg::OBJ_DEPTH);
        end else if (sfr_reg == can_rx_obj_pkg::UA_OFS) begin
            sfr_rdata[11:0] = sel_ua;
        end
    end

    wire [31:0] rd_mux = ram_sel ? ram[ram_ofs[9:2]]
                       : sfr_sel ? sfr_rdata : 32'h0000_0000;

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clock) begin
        if (ram_we) ram[wr_ptr_reg] <= ram_wdata;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg     <= can_rx_obj_pkg::ST_IDLE;
            hdr_reg       <= '0;
            wr_ptr_reg    <= 8'h00;
            word_cnt_reg  <= 5'h00;
            hdr_ready_reg <= 1'b0;
            remote_reg    <= 1'b0;
            drop_reg      <= 1'b0;
        end else begin
            state_reg     <= state_next;
            hdr_ready_reg <= state_next == can_rx_obj_pkg::ST_IDLE;
            if (hdr_take) hdr_reg <= hdr;
            if (hdr_take) wr_ptr_reg <= new_ofs[9:2];
            else if (ram_we) wr_ptr_reg <= wr_ptr_reg + 8'h01;
            if (hdr_take) word_cnt_reg <= 5'h00;
            else if (buf_pop && data_fit) word_cnt_reg <= word_cnt_reg + 5'h01;
            remote_reg <= state_reg == can_rx_obj_pkg::ST_DONE
                       && hdr_reg.rtr && !hdr_reg.fdf;
            drop_reg   <= state_reg == can_rx_obj_pkg::ST_ID && f_full;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stamp_reg  <= 32'h0000_0000;
            rdata_reg  <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
        end else begin
            stamp_reg  <= stamp_reg + 32'h0000_0001;
            rvalid_reg <= host_rd;
            if (host_rd) rdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge clock) begin
        for (int i = 0; i < can_rx_obj_pkg::NUM_FIFO; i++) begin
            if (!rst_n) begin
                ts_en_reg[i] <= can_rx_obj_pkg::TSEN_RESET;
                plsel_reg[i] <= can_rx_obj_pkg::PLSEL_RESET;
                head_reg[i]  <= '0;
                tail_reg[i]  <= '0;
            end else begin
                if (ctrl_wr && sfr_f == 1'(i)) begin
                    ts_en_reg[i] <= host_wdata[can_rx_obj_pkg::TSEN_BIT];
                    plsel_reg[i] <= host_wdata[can_rx_obj_pkg::PLSEL_LSB +: 3];
                end
                if (user_increment_hit && sfr_f == 1'(i))
                    tail_reg[i] <= tail_reg[i] + 1'b1;
                if (state_reg == can_rx_obj_pkg::ST_DONE && f == 1'(i))
                    head_reg[i] <= head_reg[i] + 1'b1;
            end
        end
    end

    assign hdr_ready      = hdr_ready_reg;
    assign host_rdata     = rdata_reg;
    assign host_rvalid    = rvalid_reg;
    assign remote_request = remote_reg;
    assign overflow_drop  = drop_reg;

    // ==========================================================
    // Assertions
    // ==========================================================
    wire id_wr   = ram_we && state_reg == can_rx_obj_pkg::ST_ID;
    wire ctrl_wr_obj = ram_we && state_reg == can_rx_obj_pkg::ST_CTRL;

    sequence s_id_then_ctrl;
        id_wr ##1 ctrl_wr_obj;
    endsequence

    property p_id_fields;
        @(posedge clock) disable iff (!rst_n)
        id_wr |-> ram_wdata[10:0] == hdr_reg.sid
               && ram_wdata[28:11] == hdr_reg.eid;
    endproperty
    a_id_fields: assert property (p_id_fields)
        else $error("identifier word fields misplaced");

    property p_id_bit12;
        @(posedge clock) disable iff (!rst_n)
        id_wr |-> ram_wdata[29] == hdr_reg.twelfth_identifier_bit;
    endproperty
    a_id_bit12: assert property (p_id_bit12)
        else $error("twelfth identifier bit misplaced");

    property p_ctrl_fields;
        @(posedge clock) disable iff (!rst_n)
        s_id_then_ctrl |-> ram_wdata[15:11] == hdr_reg.matched_filter_index
            && ram_wdata[8] == hdr_reg.esi && ram_wdata[7] == hdr_reg.fdf
            && ram_wdata[3:0] == hdr_reg.dlc && ram_wdata[4] == hdr_reg.ide;
    endproperty
    a_ctrl_fields: assert property (p_ctrl_fields)
        else $error("control word fields misplaced");

    property p_unimpl_zero;
        @(posedge clock) disable iff (!rst_n)
        s_id_then_ctrl |-> ram_wdata[31:16] == 16'h0000
            && ram_wdata[10:9] == 2'b00 && $past(ram_wdata[31:30]) == 2'b00;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented object bits not zero");

    property p_stamp_slot;
        @(posedge clock) disable iff (!rst_n)
        s_id_then_ctrl ##0 f_ts |=> ram_we
            && state_reg == can_rx_obj_pkg::ST_STAMP;
    endproperty
    a_stamp_slot: assert property (p_stamp_slot)
        else $error("timestamp word not third");

    property p_user_increment_empty;
        @(posedge clock) disable iff (!rst_n)
        user_increment_req && !sel_nempty |=> tail_reg[$past(sfr_f)] == $past(sel_tail);
    endproperty
    a_user_increment_empty: assert property (p_user_increment_empty)
        else $error("increment on empty fifo moved tail");

    property p_user_increment_step;
        @(posedge clock) disable iff (!rst_n)
        user_increment_hit |=> tail_reg[$past(sfr_f)] == $past(sel_tail) + 1'b1;
    endproperty
    a_user_increment_step: assert property (p_user_increment_step)
        else $error("tail not advanced by increment");

    property p_remote;
        @(posedge clock) disable iff (!rst_n)
        state_reg == can_rx_obj_pkg::ST_DONE && hdr_reg.rtr && !hdr_reg.fdf
            |=> remote_request ##1 !remote_request;
    endproperty
    a_remote: assert property (p_remote)
        else $error("remote request pulse missing");

    property p_status_read;
        @(posedge clock) disable iff (!rst_n)
        host_rd && sfr_sel && sfr_reg == can_rx_obj_pkg::STAT_OFS
            |=> host_rvalid && host_rdata[0] == $past(sel_nempty);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status not-empty bit wrong");
endmodule
`default_nettype wire

// File: hdl/can_rx_obj_pkg.sv
// Constants, field positions and carrier types of the receive object store.
// Assumes one 40 MHz clock and a synchronous active-low reset everywhere.
package can_rx_obj_pkg;

    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int NUM_FIFO   = 2;
    localparam int OBJ_DEPTH  = 4;
    localparam int PTR_W      = 3;
    localparam int RAM_WORDS  = 256;
    localparam int BUF_DEPTH  = 4;
    localparam int BEAT_W     = 33;

    // ==========================================================
    // Host address map
    // ==========================================================
    localparam logic [11:0] RAM_BASE        = 12'h400;
    localparam logic [11:0] RAM_END         = 12'h800;
    localparam logic [11:0] REGION_BYTES    = 12'h200;
    localparam logic [11:0] SFR_END         = 12'h020;
    localparam logic [3:0]  CTRL_OFS        = 4'h0;
    localparam logic [3:0]  STAT_OFS        = 4'h4;
    localparam logic [3:0]  UA_OFS          = 4'h8;
    localparam int          SFR_FIFO_BIT    = 4;

    // ==========================================================
    // Object word fields
    // ==========================================================
    localparam int SID_LSB   = 0;
    localparam int EID_LSB   = 11;
    localparam int ID12_BIT  = 29;
    localparam int DLC_LSB   = 0;
    localparam int IDE_BIT   = 4;
    localparam int RTR_BIT   = 5;
    localparam int BRS_BIT   = 6;
    localparam int FDF_BIT   = 7;
    localparam int ESI_BIT   = 8;
    localparam int FILT_LSB  = 11;

    // ==========================================================
    // Control and status register fields
    // ==========================================================
    localparam int INC_BIT    = 8;
    localparam int TSEN_BIT   = 5;
    localparam int PLSEL_LSB  = 29;
    localparam int NEMPTY_BIT = 0;
    localparam int FULL_BIT   = 1;
    localparam logic        TSEN_RESET  = 1'b0;
    localparam logic [2:0]  PLSEL_RESET = 3'h0;

    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic [10:0] sid;
        logic [17:0] eid;
        logic        twelfth_identifier_bit;
        logic        ide;
        logic        rtr;
        logic        fdf;
        logic        fast_data_rate;
        logic        esi;
        logic [4:0]  matched_filter_index;
        logic [3:0]  dlc;
        logic        target_fifo;
    } rx_header_t;

    typedef struct packed {
        logic            last;
        logic [3:0][7:0] bytes;
    } payload_beat_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ID    = 3'b001,
        ST_CTRL  = 3'b010,
        ST_STAMP = 3'b011,
        ST_DATA  = 3'b100,
        ST_DRAIN = 3'b101,
        ST_DONE  = 3'b110
    } wr_state_t;

endpackage

// File: hdl/beat_buffer.sv
// Small synchronous FIFO that holds payload beats ahead of the object writer.
// Assumes both sides run on the same clock; the reader may stall freely.
`timescale 1ns/1ps
`default_nettype none
module beat_buffer #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             in_ready_reg;
    wire              push = in_valid && in_ready_reg;
    wire              pop  = out_valid && out_ready;

    // ==========================================================
    // Occupancy
    // ==========================================================
    assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready   = in_ready_reg;
    assign out_valid  = count_reg != '0;
    assign out_data   = mem[rd_ptr_reg];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr_reg   <= '0;
            rd_ptr_reg   <= '0;
            count_reg    <= '0;
            in_ready_reg <= 1'b0;
        end else begin
            if (push) begin
                mem[wr_ptr_reg] <= in_data;
                wr_ptr_reg      <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg    <= count_next;
            in_ready_reg <= count_next < (AW+1)'(DEPTH);
        end
    end
endmodule
`default_nettype wire

// File: test/host_model.sv
// Host model: reads and writes the block's registers and message RAM.
// Assumes one clock; strobes change just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        clock,
    output logic             host_rd,
    output logic             host_wr,
    output logic      [11:0] host_addr,
    output logic      [31:0] host_wdata,
    input  wire logic [31:0] host_rdata,
    input  wire logic        host_rvalid
);
    initial begin
        host_rd = 1'b0;
        host_wr = 1'b0;
        host_addr = 12'h0;
        host_wdata = 32'h0;
    end
    // One read; the answer is taken at the edge that shows it valid.
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge clock);
        host_rd <= 1'b0;
        host_addr <= ~a;
        @(posedge clock);
        d = host_rvalid ? host_rdata : ~host_rdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= v;
        @(posedge clock);
        host_wr <= 1'b0;
        host_wdata <= ~v;
        @(posedge clock);
    endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Testbench: random frames into FIFO 0 and FIFO 1, read back through the host model.
// Assumes the store's package and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock, rst_n, hdr_valid, hdr_ready, beat_valid, beat_ready;
    logic remote_request, overflow_drop;
    logic [63:0] rnd;
    logic host_rd, host_wr, host_rvalid;
    logic [11:0] host_addr;
    logic [31:0] host_wdata, host_rdata, d, ua, tsb, st;
    can_rx_obj_pkg::rx_header_t    hdr, h, hf;
    can_rx_obj_pkg::payload_beat_t beat, bt;
    int num_errors = 0;
    int num_checks = 0;
    int num_remote = 0;
    int num_drop = 0;
    int rc;
    rx_object_store u_rx_object_store (.clock(clock), .rst_n(rst_n),
        .hdr(hdr), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .beat(beat),
        .beat_valid(beat_valid), .beat_ready(beat_ready),
        .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
        .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .remote_request(remote_request),
        .overflow_drop(overflow_drop));
    host_model u_host_model (.clock(clock), .host_rd(host_rd),
        .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid));
    function automatic logic [31:0] exp_id(input can_rx_obj_pkg::rx_header_t x);
        return {2'h0, x.twelfth_identifier_bit, x.eid, x.sid};
    endfunction
    function automatic logic [31:0] exp_ctl(input can_rx_obj_pkg::rx_header_t x);
        return {16'h0, x.matched_filter_index, 2'h0, x.esi, x.fdf,
                x.fast_data_rate, x.rtr, x.ide, x.dlc};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Counts the one-cycle pulses of the two event outputs.
    always @(posedge clock) begin
        if (remote_request === 1'b1) num_remote <= num_remote + 1;
        if (overflow_drop === 1'b1) num_drop <= num_drop + 1;
    end
    // Offers one header, then its beat if it carries payload.
    task automatic send(input can_rx_obj_pkg::rx_header_t x,
                        input can_rx_obj_pkg::payload_beat_t y);
        hdr <= x;
        beat <= y;
        hdr_valid <= 1'b1;
        do @(posedge clock); while (hdr_ready !== 1'b1);
        hdr_valid <= 1'b0;
        if (x.dlc != 4'h0) begin
            beat_valid <= 1'b1;
            do @(posedge clock); while (beat_ready !== 1'b1);
            beat_valid <= 1'b0;
        end
        repeat (12) @(posedge clock);
    endtask
    task automatic test_done();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        test_done();
    end
    initial begin
        {rst_n, hdr_valid, beat_valid, hdr, beat} = '0;
        void'($urandom(58550));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        u_host_model.wr(12'h000, 32'h100);
        u_host_model.rd(12'h008, ua);
        chk(ua, 32'h0);
        for (int i = 0; i < 6; i++) begin
            tsb = (i >= 4) ? 32'h20 : 32'h0;
            st = (i >= 4) ? 32'd20 : 32'd16;
            u_host_model.wr(12'h000, tsb);
            rnd = {$urandom, $urandom};
            h = rnd[$bits(h)-1:0];
            h.dlc = 4'h4;
            h.target_fifo = 1'b0;
            bt = {1'b1, $urandom};
            rc = num_remote;
            send(h, bt);
            chk(num_remote - rc, 32'(h.rtr & ~h.fdf));
            u_host_model.rd(12'h004, d);
            chk(d & 32'h1, 32'h1);
            u_host_model.rd(12'h008, ua);
            chk(ua, (i % 4) * st);
            u_host_model.rd(12'h400 + ua[11:0], d);
            chk(d, exp_id(h));
            u_host_model.rd(12'h404 + ua[11:0], d);
            chk(d, exp_ctl(h));
            u_host_model.rd(12'h408 + ua[11:0] + st[11:0] - 12'd16, d);
            chk(d, bt.bytes);
            u_host_model.wr(12'h000, 32'h100 | tsb);
            u_host_model.rd(12'h008, ua);
            chk(ua, ((i + 1) % 4) * st);
            $display("test %0d done", i);
        end
        u_host_model.wr(12'h010, 32'h2000_0000);
        for (int k = 0; k < 5; k++) begin
            rnd = {$urandom, $urandom};
            h = rnd[$bits(h)-1:0];
            h.dlc = 4'h0;
            h.target_fifo = 1'b1;
            if (k == 0) hf = h;
            rc = num_drop;
            send(h, bt);
            chk(num_drop - rc, 32'(k == 4));
        end
        u_host_model.rd(12'h014, d);
        chk(d & 32'h3, 32'h3);
        u_host_model.rd(12'h018, ua);
        chk(ua, 32'h200);
        u_host_model.rd(12'h400 + ua[11:0], d);
        chk(d, exp_id(hf));
        u_host_model.wr(12'h010, 32'h2000_0100);
        u_host_model.rd(12'h018, ua);
        chk(ua, 32'h214);
        $display("test overflow done");
        test_done();
    end
endmodule
`default_nettype wire
